/* File: design/snpv_pkg.sv */
// How it works
// RQ1 - read data command shifts data memory out
// RQ2 - data pin drives from edge 2 to 16
// RQ3 - only low eight read bits carry data
// RQ4 - increment command advances pointer, no data
// RQ5 - programmer loads a word before each program
// RQ6 - begin cycle erases then writes addressed word
// RQ7 - program-only cycle writes without word erase
// RQ8 - programmer bulk erases before program-only series
// RQ9 - after bulk program command, next program erases all
// RQ10 - newer bulk erase: load, bulk, begin, wait
// RQ11 - config pointer bulk erase spares configuration word
// RQ12 - older bulk erase uses commands 1,7,8 then 1,7
// RQ13 - data bulk erase: load, bulk, begin, wait
// RQ14 - configuration bit zero programmed, one erased
// RQ15 - read-only identification word, device and revision
// RQ16 - protect bits all zero enable protection
// RQ17 - rom variant bit 7 protects data memory
// RQ18 - bit 3 one disables power-up delay
// RQ19 - bit 2 one enables watchdog
// RQ20 - bits 1-0 select oscillator source
// RQ21 - flash protection: memories read zero, no writes
// RQ22 - rom protection: program zeros, data ones
// RQ23 - protect clear sequence erases everything
// RQ24 - six-bit commands, lsb first, falling edge
// RQ25 - data frame: start, fourteen bits, stop
// RQ26 - fixed six-bit command codes
// RQ27 - data memory 64 bytes, pointer wraps
// RQ28 - write latch keeps last loaded word
package snpv_pkg;
    localparam int         WORD_W       = 14;
    localparam int         CMD_W        = 6;
    localparam logic [3:0] CMD_LAST     = 4'h5;  // six command bits
    localparam logic [3:0] FRAME_LAST   = 4'hf;  // sixteen frame cycles
    localparam logic [3:0] DATA_FIRST   = 4'h1;
    localparam logic [3:0] DATA_LAST    = 4'he;
    // command codes [RQ26]
    localparam logic [5:0] CMD_LOAD_CFG = 6'h00;
    localparam logic [5:0] CMD_LOAD_PM  = 6'h02;
    localparam logic [5:0] CMD_READ_PM  = 6'h04;
    localparam logic [5:0] CMD_INC      = 6'h06;
    localparam logic [5:0] CMD_BEGIN_EP = 6'h08;
    localparam logic [5:0] CMD_BEGIN_PO = 6'h18;
    localparam logic [5:0] CMD_LOAD_DM  = 6'h03;
    localparam logic [5:0] CMD_READ_DM  = 6'h05;
    localparam logic [5:0] CMD_BULK_PM  = 6'h09;
    localparam logic [5:0] CMD_BULK_DM  = 6'h0b;
    localparam logic [5:0] CMD_SEL_A    = 6'h01;
    localparam logic [5:0] CMD_SEL_B    = 6'h07;
    // address map
    localparam logic [13:0] CFG_BASE    = 14'h2000;
    localparam logic [13:0] ID_ADDR     = 14'h2006;
    localparam logic [13:0] CFG_ADDR    = 14'h2007;
    localparam logic [3:0]  ID_IDX      = 4'h6;
    localparam logic [3:0]  CFG_IDX     = 4'h7;
    localparam int          PM_AW       = 10;
    localparam int          DM_AW       = 6;
    localparam int          CM_AW       = 4;
    localparam logic [9:0]  SWEEP_LAST  = 10'h3ff;
    // configuration word fields
    localparam logic [13:0] CFG_RESET   = 14'h3fff;
    localparam logic [13:0] CP_MASK     = 14'h3f70;
    localparam int          DP_BIT      = 7;
    localparam int          POWERUP_DELAY_TIMER_BIT    = 3;
    localparam int          WDT_BIT     = 2;
    localparam int          OSC_HI      = 1;
    localparam logic [13:0] WORD_ONES   = 14'h3fff;
    localparam logic [7:0]  BYTE_ONES   = 8'hff;
endpackage

/* File: design/snpv_core.sv */
`timescale 1ns/1ps
module snpv_core #(
    parameter bit         ROM_VARIANT = 1'b0,
    parameter bit         HAS_PROG_ONLY = 1'b1,
    parameter logic [8:0] DEV_CODE    = 9'h1a5, // arbitrary value
    parameter logic [4:0] REV_CODE    = 5'h03   // arbitrary value
) (
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic       prog_clock_pin,
    input  wire logic       prog_data_in,
    output logic            prog_data_out,
    output logic            prog_data_oe,
    input  wire logic       mode_select_hv_pin,
    output logic            code_protect_on,
    output logic            data_protect_on,
    output logic            powerup_delay_enable,
    output logic            watchdog_enable_bit,
    output logic [1:0]      osc_select_field,
    output logic            erase_busy
);
    ////////////////////////////////////////////////////////////////////
    // link side state, falling edge of the programming clock
    typedef enum logic [1:0] {
        SNPV_LK_CMD  = 2'b01,
        SNPV_LK_DATA = 2'b10
    } snpv_lk_e;

    typedef struct packed {
        logic       en_s1;
        logic       en_s2;
        snpv_lk_e   st;
        logic [3:0] cnt;
        logic [5:0] sh_cmd;
        logic [13:0] sh_dat;
        logic       rd_frame;
        logic [5:0] ev_cmd;
        logic [13:0] ev_dat;
        logic       ev_tgl;
    } snpv_lk_s;

    snpv_lk_s lk_reg;
    snpv_lk_s lk_next;
    logic     core_en_reg;
    logic     out_reg;
    logic     oe_reg;
    logic [13:0] rd_word_reg;

    // command and data framing, lsb first on falling edges
    always_comb begin
        lk_next       = lk_reg;
        lk_next.en_s1 = core_en_reg;
        lk_next.en_s2 = lk_reg.en_s1;
        if (!lk_reg.en_s2) begin
            lk_next.st       = SNPV_LK_CMD;
            lk_next.cnt      = 4'h0;
            lk_next.rd_frame = 1'b0;
            lk_next.ev_tgl   = 1'b0; // known level, no stray event
        end else begin
            case (lk_reg.st)
                SNPV_LK_CMD: begin
                    lk_next.sh_cmd = {prog_data_in, lk_reg.sh_cmd[5:1]}; // [RQ24]
                    lk_next.cnt    = lk_reg.cnt + 4'h1;
                    if (lk_reg.cnt == snpv_pkg::CMD_LAST) begin
                        lk_next.cnt    = 4'h0;
                        lk_next.ev_cmd = lk_next.sh_cmd;
                        case (lk_next.sh_cmd)
                            snpv_pkg::CMD_LOAD_CFG,
                            snpv_pkg::CMD_LOAD_PM,
                            snpv_pkg::CMD_LOAD_DM: begin
                                lk_next.st = SNPV_LK_DATA; // [RQ25]
                            end
                            snpv_pkg::CMD_READ_PM,
                            snpv_pkg::CMD_READ_DM: begin
                                lk_next.st       = SNPV_LK_DATA;
                                lk_next.rd_frame = 1'b1;
                                lk_next.ev_tgl   = ~lk_reg.ev_tgl;
                            end
                            default: begin
                                lk_next.ev_tgl = ~lk_reg.ev_tgl; // [RQ4]
                            end
                        endcase
                    end
                end
                SNPV_LK_DATA: begin
                    lk_next.cnt = lk_reg.cnt + 4'h1;
                    if (lk_reg.cnt >= snpv_pkg::DATA_FIRST &&
                        lk_reg.cnt <= snpv_pkg::DATA_LAST) begin
                        lk_next.sh_dat = {prog_data_in,
                                          lk_reg.sh_dat[13:1]}; // [RQ25]
                    end
                    if (lk_reg.cnt == snpv_pkg::FRAME_LAST) begin
                        lk_next.st       = SNPV_LK_CMD;
                        lk_next.cnt      = 4'h0;
                        lk_next.rd_frame = 1'b0;
                        if (!lk_reg.rd_frame) begin
                            lk_next.ev_dat = lk_reg.sh_dat;
                            lk_next.ev_tgl = ~lk_reg.ev_tgl;
                        end
                    end
                end
                default: begin
                    lk_next.st  = SNPV_LK_CMD;
                    lk_next.cnt = 4'h0;
                end
            endcase
        end
    end

    always_ff @(negedge prog_clock_pin) begin
        lk_reg <= lk_next;
    end

    // read drive on rising edges: bit k leaves at edge k+2, stop low
    always_ff @(posedge prog_clock_pin) begin
        if (!lk_reg.en_s2 || !lk_reg.rd_frame) begin
            oe_reg  <= 1'b0;
            out_reg <= 1'b0;
        end else if (lk_reg.cnt >= snpv_pkg::DATA_FIRST) begin
            oe_reg  <= 1'b1; // [RQ2]
            out_reg <= (lk_reg.cnt <= snpv_pkg::DATA_LAST) ?
                       rd_word_reg[lk_reg.cnt - 4'h1] : 1'b0; // [RQ1]
        end else begin
            oe_reg  <= 1'b0;
            out_reg <= 1'b0;
        end
    end

    // released at the sixteenth falling edge with the frame
    assign prog_data_oe  = oe_reg & lk_reg.rd_frame & lk_reg.en_s2; // [RQ2]
    assign prog_data_out = out_reg;

    ////////////////////////////////////////////////////////////////////
    // core side state
    typedef enum logic [1:0] {
        SNPV_CO_IDLE  = 2'b01,
        SNPV_CO_SWEEP = 2'b10
    } snpv_co_e;

    typedef struct packed {
        logic       hv_s1;
        logic       hv_s2;
        logic       tg_s1;
        logic       tg_s2;
        logic       tg_seen;
        logic [13:0] ptr;
        logic [13:0] latch;
        logic       latch_dm;
        logic [13:0] cfg;
        logic [13:0] rd_word;
        logic       bulk_pm;
        logic       bulk_dm;
        logic       sel_a;
        logic       clr_arm;
        snpv_co_e   st;
        logic [9:0] sw_cnt;
        logic       sw_pm;
        logic       sw_dm;
        logic       sw_cm;
    } snpv_co_s;

    snpv_co_s co_reg;
    snpv_co_s co_next;

    logic [13:0] pm_mem [0:(1 << snpv_pkg::PM_AW) - 1];
    logic [7:0]  dm_mem [0:(1 << snpv_pkg::DM_AW) - 1];
    logic [13:0] cm_mem [0:(1 << snpv_pkg::CM_AW) - 1];

    logic        pm_we;
    logic [9:0]  pm_wa;
    logic [13:0] pm_wd;
    logic        dm_we;
    logic [5:0]  dm_wa;
    logic [7:0]  dm_wd;
    logic        cm_we;
    logic [3:0]  cm_wa;
    logic [13:0] cm_wd;
    logic        ev_go;
    logic        cp_on;
    logic        dm_prot;
    logic        in_cfg;
    logic [13:0] rd_val;
    logic [13:0] old_val;
    logic        begin_go;
    logic        po;

    // protection decode from the configuration word
    always_comb begin
        cp_on = ((co_reg.cfg & snpv_pkg::CP_MASK) == 14'h0000) &&
                (ROM_VARIANT || !co_reg.cfg[snpv_pkg::DP_BIT]); // [RQ16]
        dm_prot = cp_on ||
                  (ROM_VARIANT && !co_reg.cfg[snpv_pkg::DP_BIT]); // [RQ17]
        in_cfg = co_reg.ptr[13] && (co_reg.ptr[12:4] == 9'h000);
    end

    // readout mux for the addressed location
    always_comb begin
        old_val = pm_mem[co_reg.ptr[9:0]];
        rd_val  = cp_on ? 14'h0000 : old_val; // [RQ21] [RQ22]
        if (in_cfg) begin
            old_val = cm_mem[co_reg.ptr[3:0]];
            rd_val  = old_val;
            if (co_reg.ptr[3:0] == snpv_pkg::ID_IDX) begin
                old_val = {DEV_CODE, REV_CODE};
                rd_val  = old_val; // [RQ15]
            end else if (co_reg.ptr[3:0] == snpv_pkg::CFG_IDX) begin
                old_val = co_reg.cfg;
                rd_val  = old_val;
            end
        end
        if (co_reg.latch_dm) begin
            old_val = {6'h00, dm_mem[co_reg.ptr[5:0]]}; // [RQ27]
        end
    end

    assign ev_go    = co_reg.tg_s2 != co_reg.tg_seen;
    assign begin_go = ev_go && (lk_reg.ev_cmd == snpv_pkg::CMD_BEGIN_EP ||
                      (HAS_PROG_ONLY &&
                       lk_reg.ev_cmd == snpv_pkg::CMD_BEGIN_PO));
    assign po       = lk_reg.ev_cmd == snpv_pkg::CMD_BEGIN_PO;

    // command execution and erase sweep
    always_comb begin
        co_next         = co_reg;
        co_next.hv_s1   = mode_select_hv_pin;
        co_next.hv_s2   = co_reg.hv_s1;
        co_next.tg_s1   = lk_reg.ev_tgl;
        co_next.tg_s2   = co_reg.tg_s1;
        co_next.tg_seen = co_reg.tg_s2;
        pm_we = 1'b0;
        pm_wa = co_reg.ptr[9:0];
        pm_wd = co_reg.latch;
        dm_we = 1'b0;
        dm_wa = co_reg.ptr[5:0];
        dm_wd = co_reg.latch[7:0];
        cm_we = 1'b0;
        cm_wa = co_reg.ptr[3:0];
        cm_wd = co_reg.latch;
        if (!co_reg.hv_s2) begin
            co_next.ptr     = 14'h0000;
            co_next.bulk_pm = 1'b0;
            co_next.bulk_dm = 1'b0;
            co_next.sel_a   = 1'b0;
            co_next.clr_arm = 1'b0;
        end
        case (co_reg.st)
            SNPV_CO_SWEEP: begin
                co_next.sw_cnt = co_reg.sw_cnt + 10'h001;
                pm_we = co_reg.sw_pm;
                pm_wa = co_reg.sw_cnt;
                pm_wd = snpv_pkg::WORD_ONES;
                dm_we = co_reg.sw_dm && (co_reg.sw_cnt[9:6] == 4'h0);
                dm_wa = co_reg.sw_cnt[5:0];
                dm_wd = snpv_pkg::BYTE_ONES;
                cm_we = co_reg.sw_cm && (co_reg.sw_cnt[9:4] == 6'h00) &&
                        (co_reg.sw_cnt[3:0] != snpv_pkg::CFG_IDX); // [RQ11]
                cm_wa = co_reg.sw_cnt[3:0];
                cm_wd = snpv_pkg::WORD_ONES;
                if (co_reg.sw_cnt == snpv_pkg::SWEEP_LAST) begin
                    co_next.st = SNPV_CO_IDLE;
                end
            end
            SNPV_CO_IDLE: begin
                if (co_reg.hv_s2 && ev_go) begin
                    co_next.sel_a = lk_reg.ev_cmd == snpv_pkg::CMD_SEL_A;
                    co_next.sw_cnt = 10'h000;
                    case (lk_reg.ev_cmd)
                        snpv_pkg::CMD_LOAD_CFG: begin
                            co_next.ptr      = snpv_pkg::CFG_BASE;
                            co_next.latch    = lk_reg.ev_dat; // [RQ28]
                            co_next.latch_dm = 1'b0;
                        end
                        snpv_pkg::CMD_LOAD_PM: begin
                            co_next.latch    = lk_reg.ev_dat; // [RQ28]
                            co_next.latch_dm = 1'b0;
                        end
                        snpv_pkg::CMD_LOAD_DM: begin
                            co_next.latch    = lk_reg.ev_dat; // [RQ28]
                            co_next.latch_dm = 1'b1;
                        end
                        snpv_pkg::CMD_READ_PM: begin
                            co_next.rd_word = rd_val;
                        end
                        snpv_pkg::CMD_READ_DM: begin
                            co_next.rd_word = {6'h00,
                                dm_prot ? (ROM_VARIANT ? snpv_pkg::BYTE_ONES
                                           : 8'h00)
                                        : dm_mem[co_reg.ptr[5:0]]}; // [RQ3]
                        end
                        snpv_pkg::CMD_INC: begin
                            co_next.ptr = {co_reg.ptr[13],
                                           co_reg.ptr[12:0] + 13'h0001};
                        end
                        snpv_pkg::CMD_BULK_PM: begin
                            co_next.bulk_pm = 1'b1; // [RQ9]
                        end
                        snpv_pkg::CMD_BULK_DM: begin
                            co_next.bulk_dm = 1'b1;
                        end
                        snpv_pkg::CMD_SEL_B: begin
                            co_next.clr_arm = co_reg.sel_a;
                        end
                        default: begin
                        end
                    endcase
                    if (begin_go) begin
                        co_next.bulk_pm = 1'b0;
                        co_next.bulk_dm = 1'b0;
                        co_next.clr_arm = 1'b0;
                        if (co_reg.clr_arm &&
                            co_reg.ptr == snpv_pkg::CFG_ADDR) begin
                            co_next.st    = SNPV_CO_SWEEP; // [RQ23]
                            co_next.sw_pm = 1'b1;
                            co_next.sw_dm = 1'b1;
                            co_next.sw_cm = 1'b1;
                            co_next.cfg   = co_reg.latch;
                        end else if (co_reg.clr_arm) begin
                            co_next.st    = cp_on ? SNPV_CO_IDLE
                                                  : SNPV_CO_SWEEP; // [RQ12]
                            co_next.sw_pm = !co_reg.latch_dm && !ROM_VARIANT;
                            co_next.sw_dm = co_reg.latch_dm && !dm_prot;
                            co_next.sw_cm = 1'b0;
                        end else if (co_reg.bulk_pm) begin
                            co_next.st    = (cp_on || ROM_VARIANT) ?
                                            SNPV_CO_IDLE : SNPV_CO_SWEEP; // [RQ9]
                            co_next.sw_pm = 1'b1;
                            co_next.sw_dm = 1'b0;
                            co_next.sw_cm = in_cfg; // [RQ11]
                        end else if (co_reg.bulk_dm) begin
                            co_next.st    = dm_prot ? SNPV_CO_IDLE
                                                    : SNPV_CO_SWEEP;
                            co_next.sw_pm = 1'b0;
                            co_next.sw_dm = 1'b1;
                            co_next.sw_cm = 1'b0;
                        end else if (co_reg.latch_dm) begin
                            dm_we = !dm_prot; // [RQ21]
                            dm_wd = po ? (old_val[7:0] & co_reg.latch[7:0])
                                       : co_reg.latch[7:0]; // [RQ6] [RQ7]
                        end else if (in_cfg) begin
                            if (co_reg.ptr[3:0] == snpv_pkg::CFG_IDX) begin
                                co_next.cfg = po ? (old_val & co_reg.latch)
                                                 : co_reg.latch; // [RQ14]
                            end else begin
                                cm_we = co_reg.ptr[3:0] != snpv_pkg::ID_IDX;
                                cm_wd = po ? (old_val & co_reg.latch)
                                           : co_reg.latch;
                            end
                        end else begin
                            pm_we = !cp_on && !ROM_VARIANT; // [RQ21]
                            pm_wd = po ? (old_val & co_reg.latch)
                                       : co_reg.latch; // [RQ6] [RQ7]
                        end
                    end
                end
            end
            default: begin
                co_next.st = SNPV_CO_IDLE;
            end
        endcase
        if (sys_rst) begin
            co_next         = '0;
            co_next.st      = SNPV_CO_IDLE;
            co_next.cfg     = snpv_pkg::CFG_RESET;
        end
    end

    always_ff @(posedge clk) begin
        co_reg      <= co_next;
        core_en_reg <= sys_rst ? 1'b0 : co_reg.hv_s2;
    end

    // nonvolatile arrays, written one location per cycle
    always_ff @(posedge clk) begin
        if (pm_we) begin
            pm_mem[pm_wa] <= pm_wd;
        end
        if (dm_we) begin
            dm_mem[dm_wa] <= dm_wd;
        end
        if (cm_we) begin
            cm_mem[cm_wa] <= cm_wd;
        end
    end

    // readback word is quiet while a read frame shifts it out
    assign rd_word_reg          = co_reg.rd_word;
    assign code_protect_on      = cp_on;
    assign data_protect_on      = dm_prot;
    assign powerup_delay_enable = !co_reg.cfg[snpv_pkg::POWERUP_DELAY_TIMER_BIT]; // [RQ18]
    assign watchdog_enable_bit  = co_reg.cfg[snpv_pkg::WDT_BIT];  // [RQ19]
    assign osc_select_field     = co_reg.cfg[snpv_pkg::OSC_HI:0]; // [RQ20]
    assign erase_busy           = co_reg.st == SNPV_CO_SWEEP;

    ////////////////////////////////////////////////////////////////////
    // checks
    sequence s_clear_begin;
        co_reg.st == SNPV_CO_IDLE && co_reg.hv_s2 && begin_go &&
        co_reg.clr_arm && co_reg.ptr == snpv_pkg::CFG_ADDR;
    endsequence

    property p_clear_all;
        @(posedge clk) disable iff (sys_rst)
        s_clear_begin |=> erase_busy && co_reg.sw_pm && co_reg.sw_dm;
    endproperty
    a_clear_all: assert property (p_clear_all) // [RQ23]
        else $error("protect clear did not start full erase");

    property p_inc;
        @(posedge clk) disable iff (sys_rst)
        co_reg.st == SNPV_CO_IDLE && co_reg.hv_s2 && ev_go &&
        lk_reg.ev_cmd == snpv_pkg::CMD_INC |=>
        co_reg.ptr[12:0] == $past(co_reg.ptr[12:0]) + 13'h0001 &&
        co_reg.ptr[13] == $past(co_reg.ptr[13]);
    endproperty
    a_inc: assert property (p_inc) // [RQ4]
        else $error("pointer did not advance by one");

    property p_cfg_kept;
        @(posedge clk) disable iff (sys_rst)
        erase_busy |=> $stable(co_reg.cfg);
    endproperty
    a_cfg_kept: assert property (p_cfg_kept) // [RQ11]
        else $error("configuration word changed during bulk erase");

    property p_prot_read;
        @(posedge clk) disable iff (sys_rst)
        co_reg.st == SNPV_CO_IDLE && co_reg.hv_s2 && ev_go && cp_on &&
        !in_cfg && lk_reg.ev_cmd == snpv_pkg::CMD_READ_PM |=>
        co_reg.rd_word == 14'h0000;
    endproperty
    a_prot_read: assert property (p_prot_read) // [RQ21]
        else $error("protected program memory read not zero");

    property p_dm_read;
        @(posedge clk) disable iff (sys_rst)
        co_reg.st == SNPV_CO_IDLE && co_reg.hv_s2 && ev_go &&
        lk_reg.ev_cmd == snpv_pkg::CMD_READ_DM |=>
        co_reg.rd_word[13:8] == 6'h00 &&
        (!$past(dm_prot) || co_reg.rd_word[7:0] ==
         (ROM_VARIANT ? 8'hff : 8'h00));
    endproperty
    a_dm_read: assert property (p_dm_read) // [RQ3]
        else $error("data memory read word malformed");

    property p_bulk_pm;
        @(posedge clk) disable iff (sys_rst)
        co_reg.st == SNPV_CO_IDLE && co_reg.hv_s2 && begin_go &&
        co_reg.bulk_pm && !co_reg.clr_arm && !cp_on && !ROM_VARIANT |=>
        erase_busy && co_reg.sw_pm ##1 !co_reg.bulk_pm;
    endproperty
    a_bulk_pm: assert property (p_bulk_pm) // [RQ9]
        else $error("bulk program erase not started");

    property p_latch_hold;
        @(posedge clk) disable iff (sys_rst)
        !(ev_go && co_reg.hv_s2 && co_reg.st == SNPV_CO_IDLE) |=>
        $stable(co_reg.latch);
    endproperty
    a_latch_hold: assert property (p_latch_hold) // [RQ28]
        else $error("write latch changed without a load");

    property p_pin_drive;
        @(posedge prog_clock_pin) disable iff (!lk_reg.en_s2)
        prog_data_oe |-> lk_reg.rd_frame && lk_reg.cnt >= 4'h2;
    endproperty
    a_pin_drive: assert property (p_pin_drive) // [RQ2]
        else $error("data pin driven outside read frame");
endmodule

/* File: verif/snpv_prog_model.sv */
`timescale 1ns/1ps
module snpv_prog_model (
    output logic      prog_clock_pin,
    output logic      data_line,
    input  wire logic prog_data_out,
    input  wire logic prog_data_oe
);
    logic drv;
    // device value while it drives, else the programmer's own level
    assign data_line = prog_data_oe ? prog_data_out : drv;
    initial begin
        prog_clock_pin = 1'b0;
        drv = 1'b0;
    end
    // one 30 ns clock cycle, data set before rise and held past fall
    task automatic pulse(input logic b);
        drv = b;
        #7 prog_clock_pin = 1'b1;
        #15 prog_clock_pin = 1'b0;
        #8;
    endtask
    // six command bits lsb first, then the gap
    task automatic cmd(input logic [5:0] c);
        for (int i = 0; i < 6; i++) pulse(c[i]);
        #1000;
    endtask
    // command then start, fourteen bits lsb first, stop
    task automatic load(input logic [5:0] c, input logic [13:0] w);
        cmd(c);
        pulse(1'b0);
        for (int i = 0; i < 14; i++) pulse(w[i]);
        pulse(1'b0);
        #1000;
    endtask
    // read frame; own level toggles every cycle while released
    task automatic read(input logic [5:0] c, output logic [13:0] w,
                        output logic ok);
        cmd(c);
        ok = 1'b1;
        for (int i = 0; i < 16; i++) begin
            drv = ~drv;
            #7 prog_clock_pin = 1'b1;
            #15;
            if (i > 0 && i < 15) w[i-1] = data_line;
            if (i > 0 && prog_data_oe !== 1'b1) ok = 1'b0;
            prog_clock_pin = 1'b0;
            #8;
        end
        if (prog_data_oe !== 1'b0) ok = 1'b0;
        #1000;
    endtask
endmodule

/* File: verif/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
    logic        clk, sys_rst, hv, pclk, dline, dout, doe;
    logic        cp_on, dp_on, pwr_en, wdt_en, busy, ok;
    logic [1:0]  osc;
    logic [13:0] rd;
    int          n_errors = 0, check_count = 0, cycles = 0;
    snpv_core DUT (.clk(clk), .sys_rst(sys_rst),
        .prog_clock_pin(pclk), .prog_data_in(dline),
        .prog_data_out(dout), .prog_data_oe(doe),
        .mode_select_hv_pin(hv), .code_protect_on(cp_on),
        .data_protect_on(dp_on), .powerup_delay_enable(pwr_en),
        .watchdog_enable_bit(wdt_en), .osc_select_field(osc),
        .erase_busy(busy));
    snpv_prog_model prg (.prog_clock_pin(pclk), .data_line(dline),
        .prog_data_out(dout), .prog_data_oe(doe));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // compare and count
    task automatic check(input logic [13:0] seen, input logic [13:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic results();
        $display("errors=%0d checks=%0d", n_errors, check_count);
        if (n_errors == 0 && check_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // write the configuration word through load, seven steps, begin
    task automatic to_cfg(input logic [13:0] w);
        prg.load(snpv_pkg::CMD_LOAD_CFG, w);
        repeat (7) prg.cmd(snpv_pkg::CMD_INC);
        prg.cmd(snpv_pkg::CMD_BEGIN_EP);
    endtask
    // begin, then sit out the 1024-cycle sweep
    task automatic go();
        prg.cmd(snpv_pkg::CMD_BEGIN_EP);
        #5000;
    endtask
    // the 000001, 000111 pair
    task automatic pair();
        prg.cmd(snpv_pkg::CMD_SEL_A);
        prg.cmd(snpv_pkg::CMD_SEL_B);
    endtask
    // hang guard
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 90000) begin
            n_errors++;
            results();
        end
    end
    initial begin
        sys_rst = 1'b1;
        hv = 1'b0;
        repeat (6) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (3) prg.pulse(1'b0);
        check({9'h0, pwr_en, wdt_en, osc, cp_on}, 14'h000e);
        @(posedge clk);
        hv <= 1'b1;
        repeat (20) @(posedge clk);
        repeat (2) prg.pulse(1'b0);
        #1000;
        // byte write and readout at location zero
        prg.load(snpv_pkg::CMD_LOAD_DM, 14'h35a5);
        prg.cmd(snpv_pkg::CMD_BEGIN_EP);
        prg.read(snpv_pkg::CMD_READ_DM, rd, ok);
        check(rd, 14'h00a5);
        check({13'h0, ok}, 14'h0001);
        // next location, then a program-only cycle over it
        prg.cmd(snpv_pkg::CMD_INC);
        prg.load(snpv_pkg::CMD_LOAD_DM, 14'h3f5a);
        prg.cmd(snpv_pkg::CMD_BEGIN_EP);
        prg.load(snpv_pkg::CMD_LOAD_DM, 14'h00f0);
        prg.cmd(snpv_pkg::CMD_BEGIN_PO);
        prg.read(snpv_pkg::CMD_READ_DM, rd, ok);
        check(rd, 14'h0050);
        // 63 more steps land back on location zero
        repeat (63) prg.cmd(snpv_pkg::CMD_INC);
        prg.read(snpv_pkg::CMD_READ_DM, rd, ok);
        check(rd, 14'h00a5);
        // bulk erase, then a program-only write
        prg.load(snpv_pkg::CMD_LOAD_PM, 14'h3fff);
        prg.cmd(snpv_pkg::CMD_BULK_PM);
        go();
        prg.read(snpv_pkg::CMD_READ_PM, rd, ok);
        check(rd, 14'h3fff);
        prg.load(snpv_pkg::CMD_LOAD_PM, 14'h1234);
        prg.cmd(snpv_pkg::CMD_BEGIN_PO);
        prg.read(snpv_pkg::CMD_READ_PM, rd, ok);
        check(rd, 14'h1234);
        // older order: ones, 1, 7, begin, wait, 1, 7
        prg.load(snpv_pkg::CMD_LOAD_PM, 14'h3fff);
        pair();
        go();
        pair();
        prg.read(snpv_pkg::CMD_READ_PM, rd, ok);
        check(rd, 14'h3fff);
        prg.load(snpv_pkg::CMD_LOAD_DM, 14'h3fff);
        prg.cmd(snpv_pkg::CMD_BULK_DM);
        go();
        prg.read(snpv_pkg::CMD_READ_DM, rd, ok);
        check(rd, 14'h00ff);
        to_cfg(14'h3ff2);
        check({9'h0, pwr_en, wdt_en, osc, cp_on}, 14'h0014);
        prg.load(snpv_pkg::CMD_LOAD_DM, 14'h0011);
        prg.cmd(snpv_pkg::CMD_BEGIN_EP);
        // all protect bits low turns protection on
        to_cfg(14'h000f);
        check({13'h0, cp_on}, 14'h0001);
        prg.read(snpv_pkg::CMD_READ_DM, rd, ok);
        check(rd, 14'h0000);
        prg.read(snpv_pkg::CMD_READ_PM, rd, ok);
        check(rd, 14'h000f);
        // clear protection, then the data memory byte reads erased
        prg.load(snpv_pkg::CMD_LOAD_CFG, 14'h3fff);
        repeat (7) prg.cmd(snpv_pkg::CMD_INC);
        pair();
        go();
        pair();
        check({13'h0, cp_on}, 14'h0000);
        prg.read(snpv_pkg::CMD_READ_DM, rd, ok);
        check(rd, 14'h00ff);
        results();
    end
endmodule
